// *** fmpc_pkg.sv ***
// fmpc_pkg: constants, opcodes, register map and carrier types for the
// flash mode and power-up controller.
// assumes a 10 MHz register clock and an spi link clock from the host.
package fmpc_pkg;

  // register clock
  localparam int CLK_PERIOD_NS = 100;

  // write-delay after power-on reset release, least time
  localparam int PUW_TIME_MS = 3;
  localparam int PUW_CYCLES =
    (PUW_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // select-delay after supply valid, least time
  localparam int SEL_TIME_US = 10;
  localparam int SEL_CYCLES =
    (SEL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // instruction codes
  localparam logic [7:0] OP_HIGH_PERF = 8'hA3;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] CRM_RESET_BYTE = 8'hFF;

  // link bit counts
  localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
  localparam logic [5:0] HPM_LAST_BIT = 6'h1F;
  localparam logic [5:0] CRM_QUAD_LAST = 6'h07;
  localparam logic [5:0] CRM_DUAL_LAST = 6'h0F;
  localparam logic [5:0] LINK_CNT_MAX = 6'h3F;

  // values after reset
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ARRAY_ERASED = 8'hFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int STATUS_WEL_BIT = 1;

  // apb register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATE = 12'h004;
  localparam logic [11:0] REG_FLASH_SR = 12'h008;
  localparam logic [11:0] REG_LAST_OP = 12'h00C;

  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_HIGH_PERF,
    MODE_DEEP_PD
  } fmpc_mode_t;

  typedef enum logic [1:0] {
    EVT_CMD,
    EVT_HPM,
    EVT_CRM
  } fmpc_evt_kind_t;

  typedef struct packed {
    fmpc_evt_kind_t kind;
    logic [7:0] opcode;
  } fmpc_evt_t;

  typedef struct packed {
    logic high_perf_state;
    logic deep_pd;
    logic write_enable_latch;
    logic cont_read_aux_bit;
    logic cont_read_hold_bit;
  } fmpc_flags_t;

endpackage : fmpc_pkg

// *** fmpc.sv ***
// fmpc: instruction-level mode and power-up control of a quad-i/o flash.
// assumes an apb master on pclk, and a host that drives sclk and cs_n;
// sclk stops while cs_n is high. presetn is the power-on reset.
//
// Summary of operation
// - opcode A3h plus three dummy bytes enters the high-performance state
// - release-from-power-down ABh returns high-performance state to standby
// - write-enable 06h or power-down B9h also leaves high-performance state
// - continuous-read reset sets the hold bit, ending continuous read
// - in quad continuous read, eight all-ones clocks end the mode
// - in dual continuous read, sixteen all-ones clocks end the mode
// - both continuous-read mode bits clear at power-on
// - during power-on reset presetn logic is held and no instruction is accepted; pready stays high
// - write-class instructions ignored until the write-delay has passed
// - read instructions accepted once the select-delay has passed
// - power-up leaves the device in standby, not deep power-down
// - power-up clears the write enable latch
// - array reads erased all ones, status register reads zero
// - in deep power-down only the wake instruction is obeyed; a continuous-read reset still sets the hold bit here
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
module fmpc #(
  parameter int PUW_CYCLES = fmpc_pkg::PUW_CYCLES,
  parameter int SEL_CYCLES = fmpc_pkg::SEL_CYCLES,
  parameter logic [7:0] OP_OTP_PROG = 8'h42,
  parameter logic [7:0] OP_PAGE_PROG = 8'h02,
  parameter logic [7:0] OP_DUAL_PROG = 8'hA2,
  parameter logic [7:0] OP_QUAD_PROG = 8'h32,
  parameter logic [7:0] OP_SECTOR_ERASE = 8'h20,
  parameter logic [7:0] OP_BLOCK_ERASE = 8'hD8,
  parameter logic [7:0] OP_CHIP_ERASE = 8'hC7,
  parameter logic [7:0] OP_STATUS_WRITE = 8'h01,
  parameter logic [7:0] OP_READ = 8'h03,
  parameter logic [7:0] OP_FAST_READ = 8'h0B,
  parameter logic [7:0] OP_DUAL_READ = 8'hBB,
  parameter logic [7:0] OP_QUAD_READ = 8'hEB
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic mode_load,
  input wire logic [1:0] mode_bits,
  input wire logic mode_quad,
  input wire logic wel_clear,
  output fmpc_pkg::fmpc_flags_t flags,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic read_allowed,
  output logic write_allowed,
  output logic [7:0] status_byte,
  output logic [7:0] fill_byte
);

  localparam int PUW_W = $clog2(PUW_CYCLES + 1);
  localparam int SEL_W = $clog2(SEL_CYCLES + 1);

  function automatic logic is_write_class(input logic [7:0] op);
    is_write_class = (op == fmpc_pkg::OP_WRITE_EN) ||
      (op == OP_OTP_PROG) || (op == OP_PAGE_PROG) ||
      (op == OP_DUAL_PROG) || (op == OP_QUAD_PROG) ||
      (op == OP_SECTOR_ERASE) || (op == OP_BLOCK_ERASE) ||
      (op == OP_CHIP_ERASE) || (op == OP_STATUS_WRITE);
  endfunction : is_write_class

  function automatic logic is_read_class(input logic [7:0] op);
    is_read_class = (op == OP_READ) || (op == OP_FAST_READ) ||
      (op == OP_DUAL_READ) || (op == OP_QUAD_READ);
  endfunction : is_read_class

  // ---------------- link domain (sclk) ----------------
  logic [5:0] lk_cnt_q;
  logic [7:0] lk_sh_q;
  logic [7:0] lk_op_q;
  logic lk_ones_q;
  logic lk_tgl_q;
  fmpc_pkg::fmpc_evt_t lk_evt_q;
  logic [1:0] lk_cr_s;
  logic [1:0] lk_qd_s;
  logic [7:0] lk_sh_d;
  logic lk_all_ones;
  logic lk_ones_d;
  logic [5:0] lk_crm_last;
  logic cont_active_q;
  logic cr_quad_q;

  assign lk_sh_d = {lk_sh_q[6:0], io_in[0]};
  assign lk_all_ones = lk_qd_s[1] ? (&io_in) : (&io_in[1:0]);
  assign lk_ones_d = lk_ones_q & lk_all_ones;
  assign lk_crm_last = lk_qd_s[1] ? fmpc_pkg::CRM_QUAD_LAST :
    fmpc_pkg::CRM_DUAL_LAST;

  // continuous-read state into the link domain
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      lk_cr_s <= 2'h0;
      lk_qd_s <= 2'h0;
    end else begin
      lk_cr_s <= {lk_cr_s[0], cont_active_q};
      lk_qd_s <= {lk_qd_s[0], cr_quad_q};
    end
  end

  // frame bit counter and shifter, cleared by chip select high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lk_cnt_q <= 6'h00;
      lk_sh_q <= 8'h00;
      lk_op_q <= 8'h00;
      lk_ones_q <= 1'b1;
    end else begin
      if (lk_cnt_q != fmpc_pkg::LINK_CNT_MAX) begin
        lk_cnt_q <= lk_cnt_q + 6'h01;
      end
      lk_sh_q <= lk_sh_d;
      lk_ones_q <= lk_ones_d;
      if (lk_cnt_q == fmpc_pkg::OPCODE_LAST_BIT) begin
        lk_op_q <= lk_sh_d;
      end
    end
  end

  // frame events, passed over by toggle with a held word
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      lk_tgl_q <= 1'b0;
      lk_evt_q <= '{kind: fmpc_pkg::EVT_CMD, opcode: 8'h00};
    end else if (!cs_n) begin
      if (lk_cr_s[1]) begin
        if (lk_cnt_q == lk_crm_last && lk_ones_d) begin
          lk_tgl_q <= ~lk_tgl_q;
          lk_evt_q <= '{kind: fmpc_pkg::EVT_CRM,
                        opcode: fmpc_pkg::CRM_RESET_BYTE};
        end
      end else if (lk_cnt_q == fmpc_pkg::OPCODE_LAST_BIT) begin
        lk_tgl_q <= ~lk_tgl_q;
        lk_evt_q <= '{kind: fmpc_pkg::EVT_CMD, opcode: lk_sh_d};
      end else if (lk_cnt_q == fmpc_pkg::HPM_LAST_BIT &&
                   lk_op_q == fmpc_pkg::OP_HIGH_PERF) begin
        lk_tgl_q <= ~lk_tgl_q;
        lk_evt_q <= '{kind: fmpc_pkg::EVT_HPM, opcode: lk_op_q};
      end
    end
  end

  // ---------------- register domain (pclk) ----------------
  logic [2:0] tg_s;
  logic evt_fire;
  fmpc_pkg::fmpc_evt_t evt;
  logic [31:0] ctrl_q;
  logic link_en;
  logic ev_cmd;
  logic ev_hpm;
  logic ev_crm;
  logic cmd_ok;
  logic in_dpd;
  fmpc_pkg::fmpc_mode_t mode_q;
  logic wel_q;
  logic hold_q;
  logic aux_q;
  logic [PUW_W-1:0] puw_cnt_q;
  logic puw_done_q;
  logic [SEL_W-1:0] sel_cnt_q;
  logic sel_done_q;
  logic cmd_valid_q;
  logic [7:0] cmd_opcode_q;
  logic [7:0] last_op_q;
  logic [7:0] sr_q;
  logic [7:0] fill_q;
  logic up_q;

  // toggle synchroniser; the held word is stable once the edge shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tg_s <= 3'h0;
    end else begin
      tg_s <= {tg_s[1:0], lk_tgl_q};
    end
  end

  assign evt_fire = tg_s[2] ^ tg_s[1];
  assign evt = lk_evt_q;
  assign link_en = ctrl_q[0];
  assign ev_cmd = evt_fire && link_en && evt.kind == fmpc_pkg::EVT_CMD;
  assign ev_hpm = evt_fire && link_en && evt.kind == fmpc_pkg::EVT_HPM;
  assign ev_crm = evt_fire && link_en && evt.kind == fmpc_pkg::EVT_CRM;
  assign in_dpd = mode_q == fmpc_pkg::MODE_DEEP_PD;
  assign cmd_ok = ev_cmd && sel_done_q &&
    (in_dpd ? (evt.opcode == fmpc_pkg::OP_WAKE) :
     (!is_write_class(evt.opcode) || puw_done_q));

  // power-up delays, counted from power-on reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      puw_cnt_q <= '0;
      puw_done_q <= 1'b0;
    end else if (!puw_done_q) begin
      if (puw_cnt_q == PUW_W'(PUW_CYCLES - 1)) begin
        puw_done_q <= 1'b1;
      end else begin
        puw_cnt_q <= puw_cnt_q + PUW_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cnt_q <= '0;
      sel_done_q <= 1'b0;
    end else if (!sel_done_q) begin
      if (sel_cnt_q == SEL_W'(SEL_CYCLES - 1)) begin
        sel_done_q <= 1'b1;
      end else begin
        sel_cnt_q <= sel_cnt_q + SEL_W'(1);
      end
    end
  end

  // power mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= fmpc_pkg::MODE_STANDBY;
    end else if (cmd_ok) begin
      case (evt.opcode)
        fmpc_pkg::OP_WAKE: begin
          mode_q <= fmpc_pkg::MODE_STANDBY;
        end
        fmpc_pkg::OP_POWER_DOWN: begin
          mode_q <= fmpc_pkg::MODE_DEEP_PD;
        end
        fmpc_pkg::OP_WRITE_EN: begin
          if (mode_q == fmpc_pkg::MODE_HIGH_PERF) begin
            mode_q <= fmpc_pkg::MODE_STANDBY;
          end
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end else if (ev_hpm && sel_done_q && !in_dpd) begin
      mode_q <= fmpc_pkg::MODE_HIGH_PERF;
    end
  end

  // write enable latch; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wel_q <= 1'b0;
    end else if (cmd_ok && evt.opcode == fmpc_pkg::OP_WRITE_EN) begin
      wel_q <= 1'b1;
    end else if (wel_clear) begin
      wel_q <= 1'b0;
    end
  end

  // continuous-read mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
      aux_q <= 1'b0;
      cr_quad_q <= 1'b0;
    end else if (ev_crm) begin
      hold_q <= 1'b1;
    end else if (mode_load) begin
      aux_q <= mode_bits[1];
      hold_q <= mode_bits[0];
      cr_quad_q <= mode_quad;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_active_q <= 1'b0;
    end else begin
      cont_active_q <= aux_q && !hold_q;
    end
  end

  // accepted instruction handed to the instruction engines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid_q <= 1'b0;
      cmd_opcode_q <= 8'h00;
      last_op_q <= 8'h00;
    end else begin
      cmd_valid_q <= cmd_ok;
      if (cmd_ok) begin
        cmd_opcode_q <= evt.opcode;
        last_op_q <= evt.opcode;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end

  // ---------------- apb slave ----------------
  logic apb_setup;
  logic apb_wr;
  logic apb_hit;
  logic [31:0] rd_mux;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign apb_hit = (paddr == fmpc_pkg::REG_CTRL) ||
    (paddr == fmpc_pkg::REG_STATE) || (paddr == fmpc_pkg::REG_FLASH_SR) ||
    (paddr == fmpc_pkg::REG_LAST_OP);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      fmpc_pkg::REG_CTRL: rd_mux = ctrl_q;
      fmpc_pkg::REG_STATE: rd_mux = {23'h000000, cr_quad_q, cont_active_q,
        sel_done_q, puw_done_q, aux_q, hold_q, wel_q, mode_q};
      fmpc_pkg::REG_FLASH_SR: rd_mux = {24'h000000, status_byte};
      fmpc_pkg::REG_LAST_OP: rd_mux = {24'h000000, last_op_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !apb_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= fmpc_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == fmpc_pkg::REG_CTRL && pstrb[0]) begin
      ctrl_q <= {31'h00000000, pwdata[0]};
    end
  end

  // flash status register, write enable bit is held apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= fmpc_pkg::STATUS_RESET;
      fill_q <= fmpc_pkg::ARRAY_ERASED;
    end else if (apb_wr && paddr == fmpc_pkg::REG_FLASH_SR && pstrb[0]) begin
      sr_q <= pwdata[7:0];
    end
  end

  always_comb begin
    status_byte = sr_q;
    status_byte[fmpc_pkg::STATUS_WEL_BIT] = wel_q;
  end

  assign pready = 1'b1;
  assign flags = '{high_perf_state: mode_q == fmpc_pkg::MODE_HIGH_PERF,
                   deep_pd: in_dpd, write_enable_latch: wel_q,
                   cont_read_aux_bit: aux_q, cont_read_hold_bit: hold_q};
  assign cmd_valid = cmd_valid_q;
  assign cmd_opcode = cmd_opcode_q;
  assign read_allowed = sel_done_q;
  assign write_allowed = sel_done_q && puw_done_q;
  assign fill_byte = fill_q;

  // ---------------- assertions ----------------
  property p_hpm_enter;
    @(posedge pclk) disable iff (!presetn)
    (ev_hpm && sel_done_q && !in_dpd) |=>
      (mode_q == fmpc_pkg::MODE_HIGH_PERF) [*2];
  endproperty
  a_hpm_enter: assert property (p_hpm_enter)
    else $error("high-performance entry missed");

  property p_wake_exit;
    @(posedge pclk) disable iff (!presetn)
    (cmd_ok && evt.opcode == fmpc_pkg::OP_WAKE) |=>
      (mode_q == fmpc_pkg::MODE_STANDBY) && cmd_valid_q;
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("wake did not return to standby");

  property p_hpm_leave;
    @(posedge pclk) disable iff (!presetn)
    (cmd_ok && mode_q == fmpc_pkg::MODE_HIGH_PERF &&
     (evt.opcode == fmpc_pkg::OP_WRITE_EN ||
      evt.opcode == fmpc_pkg::OP_POWER_DOWN)) |=>
      !flags.high_perf_state;
  endproperty
  a_hpm_leave: assert property (p_hpm_leave)
    else $error("high-performance state not left");

  property p_crm_hold;
    @(posedge pclk) disable iff (!presetn)
    ev_crm |=> hold_q ##1 !cont_active_q;
  endproperty
  a_crm_hold: assert property (p_crm_hold)
    else $error("continuous read not released");

  property p_quad_exit;
    @(negedge sclk) disable iff (cs_n)
    (lk_cr_s[1] && lk_qd_s[1] && lk_cnt_q == 6'h08 && lk_ones_q) |->
      (lk_tgl_q != $past(lk_tgl_q)) && lk_evt_q.kind == fmpc_pkg::EVT_CRM;
  endproperty
  a_quad_exit: assert property (p_quad_exit)
    else $error("quad all-ones reset not seen");

  property p_dual_exit;
    @(negedge sclk) disable iff (cs_n)
    (lk_cr_s[1] && !lk_qd_s[1] && lk_cnt_q == 6'h10 && lk_ones_q) |->
      (lk_tgl_q != $past(lk_tgl_q)) && lk_evt_q.kind == fmpc_pkg::EVT_CRM;
  endproperty
  a_dual_exit: assert property (p_dual_exit)
    else $error("dual all-ones reset not seen");

  property p_por_bits;
    @(posedge pclk) disable iff (!presetn)
    !up_q |-> !hold_q && !aux_q && !cont_active_q;
  endproperty
  a_por_bits: assert property (p_por_bits)
    else $error("mode bits not clear after reset");

  property p_puw_block;
    @(posedge pclk) disable iff (!presetn)
    (ev_cmd && is_write_class(evt.opcode) && !puw_done_q) |=>
      !cmd_valid_q && !wel_q;
  endproperty
  a_puw_block: assert property (p_puw_block)
    else $error("write-class accepted before write delay");

  property p_read_ok;
    @(posedge pclk) disable iff (!presetn)
    (ev_cmd && is_read_class(evt.opcode) && sel_done_q && !in_dpd) |=>
      cmd_valid_q && cmd_opcode_q == $past(evt.opcode);
  endproperty
  a_read_ok: assert property (p_read_ok)
    else $error("read refused after select delay");

  property p_por_standby;
    @(posedge pclk) disable iff (!presetn)
    !up_q |-> mode_q == fmpc_pkg::MODE_STANDBY && !flags.deep_pd;
  endproperty
  a_por_standby: assert property (p_por_standby)
    else $error("not in standby after reset");

  property p_por_wel;
    @(posedge pclk) disable iff (!presetn)
    !up_q |-> !wel_q && !status_byte[fmpc_pkg::STATUS_WEL_BIT];
  endproperty
  a_por_wel: assert property (p_por_wel)
    else $error("write enable latch set after reset");

  property p_por_status;
    @(posedge pclk) disable iff (!presetn)
    !up_q |-> status_byte == 8'h00 && fill_byte == 8'hFF;
  endproperty
  a_por_status: assert property (p_por_status)
    else $error("delivery state wrong after reset");

  property p_dpd_ignore;
    @(posedge pclk) disable iff (!presetn)
    (ev_cmd && in_dpd && evt.opcode != fmpc_pkg::OP_WAKE) |=>
      flags.deep_pd && !cmd_valid_q;
  endproperty
  a_dpd_ignore: assert property (p_dpd_ignore)
    else $error("instruction obeyed in deep power-down");

  property p_por_hpm;
    @(posedge pclk) disable iff (!presetn)
    !up_q |-> !flags.high_perf_state;
  endproperty
  a_por_hpm: assert property (p_por_hpm)
    else $error("high-performance state set after reset");

endmodule : fmpc

// *** fmpc_host.sv ***
// fmpc_host: spi host model driving sclk, cs_n and io_in.
// assumes the controller samples io_in on rising sclk.
`timescale 1ns/100ps
module fmpc_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end

  // shifts n bits msb first, all lines carry the bit
  task automatic xfer(input logic [31:0] val, input int n);
    #7;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      io_in = {4{val[i]}};
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    io_in = ~io_in;
  endtask : xfer
endmodule : fmpc_host

// *** tb_top.sv ***
// tb_top: self-checking bench for the mode and power-up controller.
// assumes fmpc_pkg and fmpc_host are compiled first.
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, io_in;
  logic sclk, cs_n, mode_load, mode_quad, wel_clear, cmd_valid;
  logic [1:0] mode_bits;
  logic read_allowed, write_allowed;
  logic [7:0] cmd_opcode, status_byte, fill_byte;
  fmpc_pkg::fmpc_flags_t flags;
  int error_cnt = 0;
  int checks = 0;
  int valid_cnt = 0;

  // counts accepted-instruction pulses
  always @(posedge pclk) begin
    if (cmd_valid === 1'b1) begin
      valid_cnt <= valid_cnt + 1;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  fmpc #(.PUW_CYCLES(20), .SEL_CYCLES(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in), .mode_load(mode_load),
    .mode_bits(mode_bits), .mode_quad(mode_quad), .wel_clear(wel_clear),
    .flags(flags), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .read_allowed(read_allowed), .write_allowed(write_allowed),
    .status_byte(status_byte), .fill_byte(fill_byte)
  );

  fmpc_host u_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in));

  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [31:0] v, input int n);
    u_host.xfer(v, n);
    repeat (6) @(posedge pclk);
  endtask : frame

  task automatic load(input logic [1:0] b, input logic q);
    @(posedge pclk);
    mode_load <= 1'b1;
    mode_bits <= b;
    mode_quad <= q;
    @(posedge pclk);
    mode_load <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : load

  // reset values during and after power-on reset
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("flags", 32'(flags), 32'h0);
    chk("status", 32'(status_byte), 32'h0);
    chk("fill", 32'(fill_byte), 32'hFF);
    chk("opcode", 32'(cmd_opcode), 32'h0);
    chk("rd_ok", 32'(read_allowed), 32'h0);
    chk("wr_ok", 32'(write_allowed), 32'h0);
    chk("pready", 32'(pready), 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("flags", 32'(flags), 32'h0);
  endtask : t_reset

  // write-class refused before write-delay, reads accepted
  task automatic t_power;
    int v0;
    for (int i = 0; i < 40 && read_allowed !== 1'b1; i++) @(posedge pclk);
    chk("rd_ok", 32'(read_allowed), 32'h1);
    v0 = valid_cnt;
    frame(32'h06, 8);
    chk("opcode", 32'(cmd_opcode), 32'h0);
    chk("flags", 32'(flags), 32'h0);
    chk("valid", 32'(valid_cnt - v0), 32'h0);
    v0 = valid_cnt;
    frame(32'h03, 8);
    chk("opcode", 32'(cmd_opcode), 32'h03);
    chk("valid", 32'(valid_cnt - v0), 32'h1);
    for (int i = 0; i < 40 && write_allowed !== 1'b1; i++) @(posedge pclk);
    chk("wr_ok", 32'(write_allowed), 32'h1);
  endtask : t_power

  // high-performance entry and every exit, deep power-down gating
  task automatic t_hpm;
    frame(32'hA300_0000, 32);
    chk("flags", 32'(flags), 32'h10);
    frame(32'h06, 8);
    chk("flags", 32'(flags), 32'h04);
    chk("status", 32'(status_byte), 32'h02);
    frame(32'hA300_0000, 32);
    frame(32'hB9, 8);
    chk("flags", 32'(flags), 32'h0C);
    frame(32'hA300_0000, 32);
    frame(32'h06, 8);
    chk("flags", 32'(flags), 32'h0C);
    chk("opcode", 32'(cmd_opcode), 32'hB9);
    frame(32'hAB, 8);
    chk("flags", 32'(flags), 32'h04);
    frame(32'hA300_0000, 32);
    frame(32'hAB, 8);
    chk("flags", 32'(flags), 32'h04);
    @(posedge pclk);
    wel_clear <= 1'b1;
    @(posedge pclk);
    wel_clear <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("flags", 32'(flags), 32'h0);
  endtask : t_hpm

  // continuous read reset in quad and dual operation
  task automatic t_crm;
    load(2'b10, 1'b1);
    chk("flags", 32'(flags), 32'h02);
    frame(32'hFF, 8);
    chk("flags", 32'(flags), 32'h03);
    load(2'b10, 1'b0);
    frame(32'hFF, 8);
    chk("flags", 32'(flags), 32'h02);
    frame(32'hFFFF, 16);
    chk("flags", 32'(flags), 32'h03);
    frame(32'h0B, 8);
    chk("opcode", 32'(cmd_opcode), 32'h0B);
  endtask : t_crm

  // register map, unmapped address and link disable
  task automatic t_regs;
    apb(1'b0, fmpc_pkg::REG_CTRL, 32'h0);
    chk("ctrl", rd, fmpc_pkg::CTRL_RESET);
    apb(1'b0, fmpc_pkg::REG_LAST_OP, 32'h0);
    chk("last_op", rd, 32'h0B);
    apb(1'b0, fmpc_pkg::REG_FLASH_SR, 32'h0);
    chk("flash_sr", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    apb(1'b1, fmpc_pkg::REG_CTRL, 32'h0);
    frame(32'hB9, 8);
    chk("flags", 32'(flags), 32'h03);
    apb(1'b1, fmpc_pkg::REG_CTRL, 32'h1);
    frame(32'h06, 8);
    frame(32'hA300_0000, 32);
    chk("flags", 32'(flags), 32'h17);
    apb(1'b0, fmpc_pkg::REG_STATE, 32'h0);
    chk("state", rd, 32'h7D);
  endtask : t_regs

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    mode_load = 1'b0;
    mode_bits = 2'b00;
    mode_quad = 1'b0;
    wel_clear = 1'b0;
    t_reset();
    t_power();
    t_hpm();
    t_crm();
    t_regs();
    t_reset();
    finish_test();
  end

  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
endmodule : tb_top
